//--- sfs_pkg.sv
// constants and types for the fill-file and halt instruction executor
// Summary of operation
// RULE1: fill file writes FFh, flags untouched
// RULE2: bank bit selects access bank or bank register
// RULE3: indexed offset when a=0, extended, f<=5Fh
// RULE4: halt clears the powerdown flag
// RULE5: halt sets the timeout flag
// RULE6: halt clears watchdog counter and postscaler
// RULE7: halt stops oscillator in fourth phase
// RULE8: watchdog wake-up clears the timeout flag
package sfs_pkg;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [6:0] SFS_FILL_OPC = 7'h34;
  localparam logic [15:0] SFS_HALT_OPC = 16'h0003;
  localparam logic [7:0] SFS_ONES = 8'hFF;
  localparam logic [7:0] SFS_INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] SFS_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] SFS_ACCESS_HIGH_BANK = 4'hF;
  localparam int SFS_OPC_POS = 9;
  localparam int SFS_BANK_BIT_POS = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic SFS_TIMEOUT_RESET = 1'b1;
  localparam logic SFS_POWERDOWN_RESET = 1'b1;
  localparam logic [7:0] SFS_WDT_RESET = 8'h00;
  localparam logic [7:0] SFS_POST_RESET = 8'h00;
  typedef enum logic [1:0] {SFS_Q1, SFS_Q2, SFS_Q3, SFS_Q4} sfs_phase_t;
endpackage

//--- sfs_phase.sv
// four-phase instruction cycle sequencer
`timescale 1ns/100ps
`default_nettype none
module sfs_phase
  import sfs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output sfs_phase_t phase
);
  // stalls in place while the oscillator is stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= SFS_Q1;
    end else if (run) begin
      unique case (phase)
        SFS_Q1: phase <= SFS_Q2;
        SFS_Q2: phase <= SFS_Q3;
        SFS_Q3: phase <= SFS_Q4;
        SFS_Q4: phase <= SFS_Q1;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- sfs_exec.sv
// executor for the fill-file and halt instructions
`timescale 1ns/100ps
`default_nettype none
module sfs_exec
  import sfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic EXT_SET_EN,
  input wire logic [3:0] BANK_SELECT_REG,
  input wire logic [11:0] INDEX_BASE,
  input wire logic WAKE,
  input wire logic WAKE_BY_WATCHDOG,
  input wire logic WATCHDOG_TICK,
  output logic [1:0] PHASE,
  output logic FILE_WE,
  output logic [11:0] FILE_ADDR,
  output logic [7:0] FILE_WDATA,
  output logic TIMEOUT_FLAG,
  output logic POWERDOWN_FLAG,
  output logic [7:0] WATCHDOG_COUNTER,
  output logic [7:0] WATCHDOG_POST,
  output logic OSC_STOPPED
);
  sfs_phase_t phase;
  logic [15:0] ir;
  logic ir_fill;
  logic ir_halt;
  logic wake_s1, wake_s2, wake_s3;
  logic wwd_s1, wwd_s2, wwd_s3;
  logic wake_req;
  logic [11:0] next_addr;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      wwd_s1 <= 1'b0;
      wwd_s2 <= 1'b0;
      wwd_s3 <= 1'b0;
    end else begin
      wake_s1 <= WAKE;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      wwd_s1 <= WAKE_BY_WATCHDOG;
      wwd_s2 <= wwd_s1;
      wwd_s3 <= wwd_s2;
    end
  end
  assign wake_req = wake_s2 & wake_s3;

  // ****************************************
  // phase sequencer
  // ****************************************
  sfs_phase u_phase (
    .clk(CLK),
    .reset_n(RESET_N),
    .run(!OSC_STOPPED),
    .phase(phase)
  );
  assign PHASE = phase;

  // ****************************************
  // decode
  // ****************************************
  // instruction is latched in Q1 so it holds steady for the whole cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ir <= 16'h0000;
    end else if (phase == SFS_Q1 && !OSC_STOPPED) begin
      ir <= INSTR_VALID ? INSTR : 16'h0000;
    end
  end
  // RULE1: fill opcode decode
  assign ir_fill = (ir[15:SFS_OPC_POS] == SFS_FILL_OPC);
  assign ir_halt = (ir == SFS_HALT_OPC);

  // ****************************************
  // operand address
  // ****************************************
  always_comb begin
    next_addr = {BANK_SELECT_REG, ir[7:0]};
    if (!ir[SFS_BANK_BIT_POS]) begin
      // RULE3: indexed literal offset
      if (EXT_SET_EN && ir[7:0] <= SFS_INDEX_LIMIT) begin
        next_addr = INDEX_BASE + {4'h0, ir[7:0]};
      // RULE2: access bank split
      end else if (ir[7:0] < SFS_ACCESS_SPLIT) begin
        next_addr = {4'h0, ir[7:0]};
      end else begin
        next_addr = {SFS_ACCESS_HIGH_BANK, ir[7:0]};
      end
    end
  end

  // ****************************************
  // file write port
  // ****************************************
  // RULE1: write FFh in Q4, one pulse
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FILE_WE <= 1'b0;
      FILE_ADDR <= 12'h000;
      FILE_WDATA <= 8'h00;
    end else begin
      FILE_WE <= ir_fill && phase == SFS_Q4 && !OSC_STOPPED;
      if (ir_fill && phase == SFS_Q3) begin
        FILE_ADDR <= next_addr;
        FILE_WDATA <= SFS_ONES;
      end
    end
  end

  // ****************************************
  // halt and wake
  // ****************************************
  // RULE7: stop oscillator at Q4
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OSC_STOPPED <= 1'b0;
    end else if (OSC_STOPPED) begin
      if (wake_req) begin
        OSC_STOPPED <= 1'b0;
      end
    end else if (ir_halt && phase == SFS_Q4) begin
      OSC_STOPPED <= 1'b1;
    end
  end

  // RULE4: powerdown flag cleared on halt
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      POWERDOWN_FLAG <= SFS_POWERDOWN_RESET;
    end else if (ir_halt && phase == SFS_Q3 && !OSC_STOPPED) begin
      POWERDOWN_FLAG <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMEOUT_FLAG <= SFS_TIMEOUT_RESET;
    end else if (OSC_STOPPED && wake_req && wwd_s3) begin
      // RULE8: watchdog wake clears timeout
      TIMEOUT_FLAG <= 1'b0;
    end else if (ir_halt && phase == SFS_Q3 && !OSC_STOPPED) begin
      // RULE5: timeout flag set on halt
      TIMEOUT_FLAG <= 1'b1;
    end
  end

  // watchdog keeps counting in sleep; it runs off its own tick
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      WATCHDOG_COUNTER <= SFS_WDT_RESET;
      WATCHDOG_POST <= SFS_POST_RESET;
    end else if (ir_halt && phase == SFS_Q3 && !OSC_STOPPED) begin
      // RULE6: clear counter and postscaler
      WATCHDOG_COUNTER <= SFS_WDT_RESET;
      WATCHDOG_POST <= SFS_POST_RESET;
    end else if (WATCHDOG_TICK) begin
      WATCHDOG_POST <= WATCHDOG_POST + 8'h01;
      if (WATCHDOG_POST == 8'hFF) begin
        WATCHDOG_COUNTER <= WATCHDOG_COUNTER + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- sfs_chk.sv
// checker for the fill-file and halt executor
`timescale 1ns/100ps
`default_nettype none
module sfs_chk
  import sfs_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic EXT_SET_EN,
  input wire logic [3:0] BANK_SELECT_REG,
  input wire logic [11:0] INDEX_BASE,
  input wire logic WAKE_BY_WATCHDOG,
  input wire logic [1:0] PHASE,
  input wire logic FILE_WE,
  input wire logic [11:0] FILE_ADDR,
  input wire logic [7:0] FILE_WDATA,
  input wire logic TIMEOUT_FLAG,
  input wire logic POWERDOWN_FLAG,
  input wire logic [7:0] WATCHDOG_COUNTER,
  input wire logic [7:0] WATCHDOG_POST,
  input wire logic OSC_STOPPED
);
  wire logic [7:0] f = INSTR[7:0];
  wire logic [11:0] want = INSTR[8] ? {BANK_SELECT_REG, f} : EXT_SET_EN && f <= 8'h5F ?
    INDEX_BASE + {4'h0, f} : {f < 8'h60 ? 4'h0 : 4'hF, f};
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence fill_go;
    PHASE == 2'h0 && !OSC_STOPPED && INSTR_VALID && INSTR[15:9] == SFS_FILL_OPC;
  endsequence
  sequence halt_go;
    PHASE == 2'h0 && !OSC_STOPPED && INSTR_VALID && INSTR == SFS_HALT_OPC;
  endsequence
  a_fill_ones: assert property (fill_go |-> ##4 FILE_WE && FILE_WDATA == 8'hFF)
    else $error("fill data");
  a_bank_addr: assert property (fill_go ##0 INSTR[8] |-> ##4 FILE_ADDR == $past(want, 4))
    else $error("bank addr");
  a_access_addr: assert property (fill_go ##0 !INSTR[8] |-> ##4 FILE_ADDR == $past(want, 4))
    else $error("access addr");
  a_halt_pd: assert property (halt_go |-> ##3 !POWERDOWN_FLAG) else $error("powerdown");
  a_halt_to: assert property (halt_go |-> ##3 TIMEOUT_FLAG) else $error("timeout");
  a_halt_wdt: assert property (halt_go |-> ##3 WATCHDOG_COUNTER == 8'h00 && WATCHDOG_POST == 8'h00)
    else $error("watchdog");
  a_sleep_q4: assert property (halt_go |-> ##3 !OSC_STOPPED ##1 OSC_STOPPED) else $error("sleep");
  a_wdt_wake: assert property ($fell(OSC_STOPPED) && WAKE_BY_WATCHDOG |-> !TIMEOUT_FLAG)
    else $error("wake flag");
  a_fill_flags: assert property (fill_go |-> ##4 $stable(TIMEOUT_FLAG) && $stable(POWERDOWN_FLAG))
    else $error("fill touched flags");
  a_sleep_freeze: assert property (OSC_STOPPED |-> PHASE == 2'h0 && !FILE_WE)
    else $error("sleep not frozen");
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the fill-file and halt executor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sfs_pkg::*;
  logic CLK = 0, RESET_N = 0, INSTR_VALID = 0, EXT_SET_EN = 0, WAKE = 0, WAKE_BY_WATCHDOG = 0;
  logic WATCHDOG_TICK = 0, FILE_WE, TIMEOUT_FLAG, POWERDOWN_FLAG, OSC_STOPPED, was = 0;
  logic [1:0] PHASE;
  logic [3:0] BANK_SELECT_REG = 0;
  logic [11:0] INDEX_BASE = 0, FILE_ADDR;
  logic [15:0] INSTR = 0;
  logic [7:0] FILE_WDATA, WATCHDOG_COUNTER, WATCHDOG_POST;
  logic [19:0] notes[$];
  int num_errors = 0, num_checks = 0;
  sfs_exec sfs_exec_i (.*);
  always #25 CLK = ~CLK;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // m of 2 waits for the last phase, else for that oscillator level
  task automatic wait_for(input int m);
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while ((m == 2 ? PHASE !== 2'h3 : OSC_STOPPED !== m[0]) && n < 40);
    if (n == 40) begin
      num_errors++;
      finish_test();
    end
    // hand back on a rising edge so the caller drives by non-blocking assignment there
    @(posedge CLK);
  endtask
  function automatic logic [19:0] oldest();
    return notes.size() ? notes.pop_front() : 20'hXXXXX;
  endfunction
  always @(posedge CLK) begin
    #1;
    if (FILE_WE === 1'b1) chk({FILE_ADDR, FILE_WDATA}, oldest());
    // oscillator edges carry the flag and watchdog snapshot
    if (OSC_STOPPED !== was) chk({TIMEOUT_FLAG, POWERDOWN_FLAG, 2'h0, WATCHDOG_COUNTER,
      WATCHDOG_POST}, oldest());
    was = OSC_STOPPED;
  end
  initial begin
    logic [7:0] f;
    logic [3:0] b;
    logic [11:0] base;
    logic a, x;
    void'($urandom(32'h4F6E7A5A));
    repeat (8) @(posedge CLK);
    RESET_N <= 1;
    for (int k = 0; k < 12; k++) begin
      f = k < 4 ? 8'h5E + 8'(k) : 8'($urandom);
      a = k < 6 ? 1'b0 : 1'($urandom);
      x = k < 4 || 1'($urandom);
      b = 4'($urandom);
      base = 12'($urandom);
      // step 5 is a dropped slot and must not write
      if (k != 5) notes.push_back({a ? {b, f} : x && f <= 8'h5F ? base + {4'h0, f} :
        {f < 8'h60 ? 4'h0 : 4'hF, f}, 8'hFF});
      wait_for(2);
      INSTR <= {SFS_FILL_OPC, a, f};
      INSTR_VALID <= k != 5;
      EXT_SET_EN <= x;
      BANK_SELECT_REG <= b;
      INDEX_BASE <= base;
      WATCHDOG_TICK <= 1'($urandom);
    end
    wait_for(2);
    INSTR_VALID <= 0;
    $display("fill test done");
    for (int w = 1; w >= 0; w--) begin
      // load the watchdog so the halt has something to clear
      WATCHDOG_TICK <= 1;
      repeat (300) @(posedge CLK);
      WATCHDOG_TICK <= 0;
      notes.push_back(20'h80000);
      wait_for(2);
      INSTR <= SFS_HALT_OPC;
      INSTR_VALID <= 1;
      wait_for(1);
      INSTR <= 16'h0000;
      notes.push_back({~w[0], 19'h0});
      WAKE_BY_WATCHDOG <= w[0];
      WAKE <= 1;
      wait_for(0);
      WAKE <= 0;
      $display("sleep test done");
    end
    chk(20'(notes.size()), 20'h0);
    finish_test();
  end
endmodule
bind sfs_exec sfs_chk sfs_chk_i (.*);
`default_nettype wire
